// ### rtl/lite_timer_pkg.sv
// Purpose: shared constants for the dual timebase lite timer
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   register byte address is four times the register index
package lite_timer_pkg;

   // register indices; byte address = index * 4
   localparam logic [5:0] IDX_TB2_CSR     = 6'h0c;
   localparam logic [5:0] IDX_RELOAD      = 6'h0d;
   localparam logic [5:0] IDX_CNT2        = 6'h0e;
   localparam logic [5:0] IDX_TB1_CSR     = 6'h0f;
   localparam logic [5:0] IDX_CAPTURE     = 6'h10;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h11;
   localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h12;
   localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h13;
   localparam logic [5:0] IDX_NONE        = 6'h3f;
   localparam int         ADDR_W          = 8;

   // timebase_two_ctrl_status fields
   localparam int BIT_TB2_FLAG  = 0;
   localparam int BIT_TB2_IE    = 1;
   // timebase_one_capture_ctrl_status fields
   localparam int BIT_TB1_FLAG  = 3;
   localparam int BIT_TB1_IE    = 4;
   localparam int BIT_PERIOD    = 5;
   localparam int BIT_CAP_FLAG  = 6;
   localparam int BIT_CAP_IE    = 7;
   // interrupt status / clear / enable layout
   localparam int EV_TB1        = 0;
   localparam int EV_TB2        = 1;
   localparam int EV_CAP        = 2;
   localparam int EV_W          = 3;
   localparam logic [2:0] IRQ_EN_RESET = 3'h7;

   // timing: counters step once per OSC_DIV clock cycles
   localparam int         OSC_DIV       = 32;
   localparam int         BASE_PERIOD   = 8000;
   localparam logic [4:0] PRESC_LAST    = 5'(OSC_DIV - 1);
   localparam logic [7:0] CNT1_LAST     = 8'(BASE_PERIOD / OSC_DIV - 1);
   localparam logic [7:0] CNT2_LAST     = 8'hff;

   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// ### rtl/dual_timebase_lite_timer.sv
// Purpose: two 8-bit timebase counters with an 8-bit input capture, AXI4-Lite registers
// Assumes: CLK_SYS is the oscillator; HALT_MODE and CPU_IRQ_MASK come from CLK_SYS logic
// Notes:   flags also mirror into a sticky status word with write-one clear and enable
//
// Chosen here: the AXI4-Lite slave port.
module dual_timebase_lite_timer
   import lite_timer_pkg::*;
(
   input  wire logic                CLK_SYS,
   input  wire logic                RST_N,
   input  wire logic                HALT_MODE,
   input  wire logic                CPU_IRQ_MASK,
   input  wire logic                CAPTURE_EDGE_PIN,
   output      logic                IRQ,
   input  wire logic [ADDR_W-1:0]   AWADDR,
   input  wire logic                AWVALID,
   output      logic                AWREADY,
   input  wire logic [31:0]         WDATA,
   input  wire logic [3:0]          WSTRB,
   input  wire logic                WVALID,
   output      logic                WREADY,
   output      logic [1:0]          BRESP,
   output      logic                BVALID,
   input  wire logic                BREADY,
   input  wire logic [ADDR_W-1:0]   ARADDR,
   input  wire logic                ARVALID,
   output      logic                ARREADY,
   output      logic [31:0]         RDATA,
   output      logic [1:0]          RRESP,
   output      logic                RVALID,
   input  wire logic                RREADY
);

   typedef struct packed {
      logic [4:0]        presc;
      logic [7:0]        cnt1;
      logic              half;
      logic [7:0]        cnt2;
      logic [7:0]        reload;
      logic [7:0]        cap;
      logic              timebase_one_flag;
      logic              timebase_two_flag;
      logic              capture_flag;
      logic              timebase_one_irq_enable;
      logic              timebase_two_irq_enable;
      logic              capture_irq_enable;
      logic              period_select;
      logic [EV_W-1:0]   irq_en;
      logic              pin_s1;
      logic              pin_s2;
      logic              pin_s3;
      logic              aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic              w_held;
      logic [7:0]        wdata;
      logic              wlane0;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              irq;
   } state_s;

   state_s s_reg;
   state_s s_next;

   // word-aligned addresses map to an index; misaligned ones to nothing
   function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
      if (addr[1:0] != 2'h0)
         return IDX_NONE;
      return addr[ADDR_W-1:2];
   endfunction

   function automatic logic known_index(input logic [5:0] idx);
      return (idx >= IDX_TB2_CSR) && (idx <= IDX_IRQ_ENABLE);
   endfunction

   logic              tick;
   logic              cnt1_wrap;
   logic              tb1_evt;
   logic              cnt2_ovf;
   logic              cap_edge;
   logic              cap_evt;
   logic              rd_take;
   logic [5:0]        rd_idx;
   logic [5:0]        wr_idx;
   logic              wr_do;
   logic [7:0]        rd_byte;
   logic [EV_W-1:0]   flags;

   always_comb
   begin
      s_next = s_reg;
      flags = {s_reg.capture_flag, s_reg.timebase_two_flag, s_reg.timebase_one_flag};

      tick = (s_reg.presc == PRESC_LAST) && !HALT_MODE;
      if (!HALT_MODE)
      begin
         s_next.presc = s_reg.presc + 5'h01;
      end

      cnt1_wrap = tick && (s_reg.cnt1 == CNT1_LAST);
      if (tick)
      begin
         s_next.cnt1 = cnt1_wrap ? RESET_BYTE : s_reg.cnt1 + 8'h01;
      end
      // double period takes every other wrap
      if (cnt1_wrap)
      begin
         s_next.half = !s_reg.half;
      end
      tb1_evt = cnt1_wrap && (!s_reg.period_select || s_reg.half);

      cnt2_ovf = tick && (s_reg.cnt2 == CNT2_LAST);
      if (tick)
      begin
         // reload on overflow, reload value sampled only here
         s_next.cnt2 = cnt2_ovf ? s_reg.reload : s_reg.cnt2 + 8'h01;
      end

      // capture pin synchroniser; s3 is only for edge detection
      s_next.pin_s1 = CAPTURE_EDGE_PIN;
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.pin_s3 = s_reg.pin_s2;
      cap_edge = s_reg.pin_s2 != s_reg.pin_s3;
      // edges ignored while capture flag is set
      cap_evt = cap_edge && !s_reg.capture_flag;
      if (cap_evt)
      begin
         s_next.cap = s_reg.cnt1;
      end

      // read channel
      rd_take = ARVALID && s_reg.arready;
      rd_idx = reg_index(ARADDR);
      case (rd_idx)
         IDX_TB2_CSR:    rd_byte = {6'h00, s_reg.timebase_two_irq_enable, s_reg.timebase_two_flag};
         IDX_RELOAD:     rd_byte = s_reg.reload;
         IDX_CNT2:       rd_byte = s_reg.cnt2;
         IDX_TB1_CSR:    rd_byte = {s_reg.capture_irq_enable, s_reg.capture_flag, s_reg.period_select,
                                    s_reg.timebase_one_irq_enable, s_reg.timebase_one_flag, 3'h0};
         IDX_CAPTURE:    rd_byte = s_reg.cap;
         IDX_IRQ_STATUS: rd_byte = {5'h00, flags};
         IDX_IRQ_ENABLE: rd_byte = {5'h00, s_reg.irq_en};
         default:        rd_byte = RESET_BYTE;
      endcase
      if (rd_take)
      begin
         s_next.rvalid = 1'b1;
         s_next.rdata = {24'h000000, rd_byte};
         s_next.rresp = known_index(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         if (rd_idx == IDX_TB1_CSR)
         begin
            s_next.timebase_one_flag = 1'b0;
         end
         if (rd_idx == IDX_TB2_CSR)
         begin
            s_next.timebase_two_flag = 1'b0;
         end
         if (rd_idx == IDX_CAPTURE)
         begin
            s_next.capture_flag = 1'b0;
         end
      end
      else if (s_reg.rvalid && RREADY)
      begin
         s_next.rvalid = 1'b0;
      end
      s_next.arready = !s_next.rvalid;

      // write channel: address and data taken in either order
      if (AWVALID && s_reg.awready)
      begin
         s_next.aw_held = 1'b1;
         s_next.awaddr = AWADDR;
      end
      if (WVALID && s_reg.wready)
      begin
         s_next.w_held = 1'b1;
         s_next.wdata = WDATA[7:0];
         s_next.wlane0 = WSTRB[0];
      end
      wr_do = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
      wr_idx = reg_index(s_reg.awaddr);
      if (wr_do)
      begin
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = known_index(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         // flag bits are not writable; reserved bits are dropped
         if (s_reg.wlane0)
         begin
            case (wr_idx)
               IDX_TB2_CSR:
               begin
                  s_next.timebase_two_irq_enable = s_reg.wdata[BIT_TB2_IE];
               end
               IDX_RELOAD:
               begin
                  s_next.reload = s_reg.wdata;
               end
               IDX_TB1_CSR:
               begin
                  s_next.capture_irq_enable = s_reg.wdata[BIT_CAP_IE];
                  s_next.period_select = s_reg.wdata[BIT_PERIOD];
                  s_next.timebase_one_irq_enable = s_reg.wdata[BIT_TB1_IE];
               end
               IDX_IRQ_CLEAR:
               begin
                  if (s_reg.wdata[EV_TB1])
                     s_next.timebase_one_flag = 1'b0;
                  if (s_reg.wdata[EV_TB2])
                     s_next.timebase_two_flag = 1'b0;
                  if (s_reg.wdata[EV_CAP])
                     s_next.capture_flag = 1'b0;
               end
               IDX_IRQ_ENABLE:
               begin
                  s_next.irq_en = s_reg.wdata[EV_W-1:0];
               end
               default:
               begin
               end
            endcase
         end
      end
      else if (s_reg.bvalid && BREADY)
      begin
         s_next.bvalid = 1'b0;
      end
      s_next.awready = !s_next.aw_held && !s_next.bvalid;
      s_next.wready = !s_next.w_held && !s_next.bvalid;

      // hardware sets come last so a set beats a clear in the same cycle
      // timebase one, timebase two and capture flag sets
      if (tb1_evt)
      begin
         s_next.timebase_one_flag = 1'b1;
      end
      if (cnt2_ovf)
      begin
         s_next.timebase_two_flag = 1'b1;
      end
      if (cap_evt)
      begin
         s_next.capture_flag = 1'b1;
      end

      // one shared interrupt, gated by enables and CPU mask
      s_next.irq = !CPU_IRQ_MASK && |({s_next.capture_flag, s_next.timebase_two_flag, s_next.timebase_one_flag}
                   & {s_next.capture_irq_enable, s_next.timebase_two_irq_enable, s_next.timebase_one_irq_enable} & s_next.irq_en);
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         s_reg <= '0;
         s_reg.irq_en <= IRQ_EN_RESET;
         s_reg.awready <= 1'b1;
         s_reg.wready <= 1'b1;
         s_reg.arready <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign IRQ = s_reg.irq;
   assign AWREADY = s_reg.awready;
   assign WREADY = s_reg.wready;
   assign BVALID = s_reg.bvalid;
   assign BRESP = s_reg.bresp;
   assign ARREADY = s_reg.arready;
   assign RVALID = s_reg.rvalid;
   assign RDATA = s_reg.rdata;
   assign RRESP = s_reg.rresp;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   a_cnt1_hold: assert property (!tick |=> $stable(s_reg.cnt1))
      else $error("counter 1 moved without a tick");
   a_cnt1_wrap: assert property (tick && s_reg.cnt1 == 8'hf9 |=> s_reg.cnt1 == 8'h00)
      else $error("counter 1 did not wrap after f9");
   a_period_sel: assert property (tb1_evt |-> cnt1_wrap && (!s_reg.period_select || s_reg.half))
      else $error("timebase one event at wrong wrap");
   a_tb1_flag: assert property (tb1_evt |=> s_reg.timebase_one_flag)
      else $error("timebase one flag not set");
   a_tb1_rdclr: assert property (rd_take && rd_idx == IDX_TB1_CSR && !tb1_evt
                                 |=> !s_reg.timebase_one_flag)
      else $error("timebase one flag not cleared by read");
   a_cap_load: assert property (cap_evt |=> s_reg.capture_flag && s_reg.cap == $past(s_reg.cnt1))
      else $error("capture did not latch counter 1");
   a_cap_rdclr: assert property (rd_take && rd_idx == IDX_CAPTURE && !cap_evt
                                 |=> !s_reg.capture_flag)
      else $error("capture flag not cleared by read");
   a_cap_hold: assert property (s_reg.capture_flag |=> $stable(s_reg.cap))
      else $error("capture value changed while flag set");
   a_cnt2_step: assert property (tick && s_reg.cnt2 != 8'hff
                                 |=> s_reg.cnt2 == $past(s_reg.cnt2) + 8'h01)
      else $error("counter 2 did not step");
   a_cnt2_reload: assert property (cnt2_ovf |=> s_reg.cnt2 == $past(s_reg.reload)
                                   && s_reg.timebase_two_flag)
      else $error("counter 2 did not reload");
   a_tb2_rdclr: assert property (rd_take && rd_idx == IDX_TB2_CSR && !cnt2_ovf
                                 |=> !s_reg.timebase_two_flag)
      else $error("timebase two flag not cleared by read");
   a_halt_freeze: assert property (HALT_MODE |=> $stable(s_reg.cnt1) && $stable(s_reg.cnt2))
      else $error("counters moved in halt");
   a_irq_gate: assert property (IRQ |-> !$past(CPU_IRQ_MASK))
      else $error("interrupt raised while masked");
   a_bresp_time: assert property (AWVALID && AWREADY && WVALID && WREADY
                                  |=> ##1 BVALID)
      else $error("write response late");

   c_tb1_event: cover property (tb1_evt && s_reg.period_select);
   c_capture:   cover property (cap_evt ##[1:200] (rd_take && rd_idx == IDX_CAPTURE));
   c_cnt2_ovf:  cover property (cnt2_ovf && s_reg.reload != 8'h00);
   c_irq:       cover property ($rose(IRQ));

endmodule

// ### sim/capture_pin_model.sv
// Purpose: outside world driving the capture input pin
// Assumes: one clock; the pin has no pull and is always driven
// Notes:   each flip request makes one edge, rising and falling in turn
module capture_pin_model (
   input  wire logic clk,
   input  wire logic flip,
   output      logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b0;
   // edges only on request, so the bench knows when a capture is due
   always @(posedge clk)
   begin
      if (flip)
      begin
         pin <= ~pin;
      end
   end
endmodule

// ### sim/dual_timebase_lite_timer_test.sv
// Purpose: self-checking bench for the dual timebase lite timer
// Assumes: AXI4-Lite master tasks; counter 1 is modelled with integers
// Notes:   intervals are taken between irq rises, so read latency cancels
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dual_timebase_lite_timer_test import lite_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic              CLK_SYS, RST_N, HALT_MODE, CPU_IRQ_MASK, IRQ, CAPTURE_EDGE_PIN, flip;
   logic [ADDR_W-1:0] AWADDR, ARADDR;
   logic [31:0]       WDATA, RDATA, d, d2;
   logic [3:0]        WSTRB;
   logic [1:0]        BRESP, RRESP, r;
   logic              AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic              ARVALID, ARREADY, RVALID, RREADY;
   logic [7:0]        rv, rv2;
   int                errors = 0, n_checks = 0, cyc = 0, presc, c1, t0, t1, rel, m;
   localparam int     LIMIT = 95000;
   localparam int     WRAP = int'(CNT1_LAST) + 1;

   dual_timebase_lite_timer u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HALT_MODE(HALT_MODE),
      .CPU_IRQ_MASK(CPU_IRQ_MASK), .CAPTURE_EDGE_PIN(CAPTURE_EDGE_PIN), .IRQ(IRQ),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY));
   capture_pin_model u_pin (.clk(CLK_SYS), .flip(flip), .pin(CAPTURE_EDGE_PIN));

   initial
   begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end

   // reference for the hidden counter 1, frozen by halt like the prescaler
   always @(posedge CLK_SYS)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         errors++;
         print_verdict();
      end
      if (!RST_N)
      begin
         presc <= 0;
         c1 <= 0;
      end
      else if (!HALT_MODE)
      begin
         presc <= (presc + 1) % OSC_DIV;
         if (presc == OSC_DIV - 1) c1 <= (c1 + 1) % WRAP;
      end
   end

   function automatic logic [7:0] ad(input logic [5:0] i);
      return {i, 2'b00};
   endfunction

   function automatic bit near(input logic [7:0] v, input int e);
      int k;
      k = (int'(v) - e + WRAP) % WRAP;
      return k <= 1 || k == WRAP - 1;
   endfunction

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] er);
      bit aw_ok, w_ok;
      @(posedge CLK_SYS);
      AWADDR <= a;
      WDATA <= v;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         aw_ok |= AWVALID && (AWREADY === 1'b1);
         w_ok |= WVALID && (WREADY === 1'b1);
         if (aw_ok) AWVALID <= 1'b0;
         if (w_ok) WVALID <= 1'b0;
      end
      while (!(aw_ok && w_ok));
      while (BVALID !== 1'b1) @(posedge CLK_SYS);
      `CHK(BRESP, er)
      BREADY <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      @(posedge CLK_SYS);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1) @(posedge CLK_SYS);
      v = RDATA;
      rr = RRESP;
      RREADY <= 1'b0;
   endtask

   task automatic xrd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a, d, r);
      `CHK(d, e)
      `CHK(r, er)
   endtask

   // the pending flag is cleared first, so the rise seen here is a fresh event
   task automatic wait_irq(output int at);
      repeat (2) @(posedge CLK_SYS);
      while (IRQ !== 1'b1) @(posedge CLK_SYS);
      at = cyc;
   endtask

   task automatic pulse_pin();
      @(posedge CLK_SYS);
      flip <= 1'b1;
      @(posedge CLK_SYS);
      flip <= 1'b0;
   endtask

   initial
   begin
      {RST_N, HALT_MODE, CPU_IRQ_MASK, flip, AWVALID, WVALID, BREADY} = '0;
      {ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hf;
      void'($urandom(32'h62b7));
      repeat (10) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      rel = cyc;
      xrd(ad(IDX_CAPTURE), 32'h0, RESP_OKAY);
      xrd(ad(IDX_CNT2), 32'h0, RESP_OKAY);
      xrd(ad(IDX_TB2_CSR), 32'h0, RESP_OKAY);
      xrd(ad(IDX_IRQ_ENABLE), 32'(IRQ_EN_RESET), RESP_OKAY);
      xrd(ad(IDX_NONE), 32'h0, RESP_SLVERR);
      xrd(8'h31, 32'h0, RESP_SLVERR);
      wr(ad(IDX_TB1_CSR), 32'h48, 4'hf, RESP_OKAY);
      xrd(ad(IDX_TB1_CSR), 32'h0, RESP_OKAY);
      wr(ad(IDX_CAPTURE), 32'h55, 4'hf, RESP_OKAY);
      xrd(ad(IDX_CAPTURE), 32'h0, RESP_OKAY);
      $display("test reset_and_map done");
      rv = 8'($urandom_range(8'hff, 8'hc0));
      rv2 = 8'($urandom_range(8'hff, 8'hc0));
      wr(ad(IDX_RELOAD), 32'h11, 4'h0, RESP_OKAY);
      xrd(ad(IDX_RELOAD), 32'h0, RESP_OKAY);
      wr(ad(IDX_RELOAD), 32'(rv), 4'hf, RESP_OKAY);
      wr(ad(IDX_TB2_CSR), 32'h3, 4'hf, RESP_OKAY);
      xrd(ad(IDX_TB2_CSR), 32'h2, RESP_OKAY);
      wait_irq(t0);
      `CHK(t0 - rel >= 256 * OSC_DIV && t0 - rel <= 256 * OSC_DIV + 6, 1'b1)
      xrd(ad(IDX_TB2_CSR), 32'h3, RESP_OKAY);
      xrd(ad(IDX_TB2_CSR), 32'h2, RESP_OKAY);
      xrd(ad(IDX_CNT2), 32'(rv), RESP_OKAY);
      wr(ad(IDX_RELOAD), 32'(rv2), 4'hf, RESP_OKAY);
      wait_irq(t1);
      `CHK(t1 - t0, (256 - int'(rv)) * OSC_DIV)
      xrd(ad(IDX_CNT2), 32'(rv2), RESP_OKAY);
      wr(ad(IDX_TB2_CSR), 32'h0, 4'hf, RESP_OKAY);
      $display("test counter_two done");
      rd(ad(IDX_TB1_CSR), d, r);
      wr(ad(IDX_TB1_CSR), 32'h10, 4'hf, RESP_OKAY);
      wait_irq(t0);
      `CHK(c1, 0)
      xrd(ad(IDX_TB1_CSR), 32'h18, RESP_OKAY);
      wait_irq(t1);
      `CHK(t1 - t0, BASE_PERIOD)
      xrd(ad(IDX_TB1_CSR), 32'h18, RESP_OKAY);
      wr(ad(IDX_TB1_CSR), 32'h30, 4'hf, RESP_OKAY);
      wait_irq(t0);
      rd(ad(IDX_TB1_CSR), d, r);
      wait_irq(t1);
      `CHK(t1 - t0, 2 * BASE_PERIOD)
      xrd(ad(IDX_TB1_CSR), 32'h38, RESP_OKAY);
      $display("test counter_one done");
      wr(ad(IDX_TB1_CSR), 32'h80, 4'hf, RESP_OKAY);
      CPU_IRQ_MASK <= 1'b1;
      pulse_pin();
      repeat (3) @(posedge CLK_SYS);
      m = c1;
      repeat (100) @(posedge CLK_SYS);
      `CHK(IRQ, 1'b0)
      pulse_pin();
      repeat (100) @(posedge CLK_SYS);
      xrd(ad(IDX_TB1_CSR), 32'hc0, RESP_OKAY);
      CPU_IRQ_MASK <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      `CHK(IRQ, 1'b1)
      wr(ad(IDX_IRQ_ENABLE), 32'h3, 4'hf, RESP_OKAY);
      repeat (3) @(posedge CLK_SYS);
      `CHK(IRQ, 1'b0)
      wr(ad(IDX_IRQ_ENABLE), 32'h7, 4'hf, RESP_OKAY);
      repeat (3) @(posedge CLK_SYS);
      `CHK(IRQ, 1'b1)
      rd(ad(IDX_CAPTURE), d, r);
      `CHK(near(d[7:0], m), 1'b1)
      xrd(ad(IDX_TB1_CSR), 32'h80, RESP_OKAY);
      pulse_pin();
      repeat (3) @(posedge CLK_SYS);
      m = c1;
      repeat (50) @(posedge CLK_SYS);
      // the clear register must drop a flag that is really set
      rd(ad(IDX_IRQ_STATUS), d, r);
      `CHK(d[EV_CAP], 1'b1)
      wr(ad(IDX_IRQ_CLEAR), 32'h4, 4'hf, RESP_OKAY);
      rd(ad(IDX_IRQ_STATUS), d, r);
      `CHK(d[EV_CAP], 1'b0)
      rd(ad(IDX_CAPTURE), d, r);
      `CHK(near(d[7:0], m), 1'b1)
      $display("test capture done");
      HALT_MODE <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      rd(ad(IDX_CNT2), d, r);
      repeat (200) @(posedge CLK_SYS);
      xrd(ad(IDX_CNT2), d, RESP_OKAY);
      HALT_MODE <= 1'b0;
      repeat (100) @(posedge CLK_SYS);
      rd(ad(IDX_CNT2), d2, r);
      `CHK(d2 !== d, 1'b1)
      $display("test halt done");
      print_verdict();
   end
endmodule
